// file: hdl/parameter_set_sequencer.sv
// Parameter set store, live configuration and sequencing control with an APB slave
`timescale 1ns/10ps
`include "set_seq_regs.svh"

// Behaviour in brief:
// - Host software edits the live words over APB; the acquisition side runs on the
//   active set, which copies the live words while sequencing is off or being set up.
// - A load command copies one stored set into the live words; a store command writes
//   the live words back into a stored set, in configuration mode only.
// - Writes to the live words are refused with an error while armed or running, and
//   reads there keep showing the values from before sequencing began.
// - With the run flag on, the block waits for a frame start, applies set zero, then
//   follows the two advance paths of whichever set is current.
// - Auto adjustment, or both flags off, turns sequencing off altogether.
// - Limitation: a software signal in the same cycle as a frame start is dropped,
//   because the frame start branch of the advance logic is looked at first.
// - Stored sets live in flip-flops only; nothing of them survives a reset.
module parameter_set_sequencer
  import set_seq_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic frame_start_i,
  input wire logic counter2_end_i,
  input wire logic [2:0] trig_lines_i,
  output param_set_s active_cfg_o,
  output logic [31:0] aux_setting_o,
  output logic [4:0] current_set_o,
  output logic set_loaded_o,
  output logic seq_running_o
);

  // Volatile set store; nothing here reaches nonvolatile storage
  param_set_s set_mem_q [`SET_COUNT];
  set_words_t live_q; // Host-visible live words of the sequenced group
  param_set_s active_q; // What the camera actually runs on
  logic [31:0] aux_q; // Non-sequenced live setting
  logic cfg_flag_q; // Configuration-mode flag
  logic run_flag_q; // Sequencing-run flag
  logic auto_flag_q; // Automatic adjustment enable
  logic [4:0] sel_q; // Set selector for load and store
  logic [4:0] cur_q; // Current set index
  logic loaded_q; // One-cycle pulse after a set load
  // Effective sequencer mode and its next value
  seq_mode_e mode_q;
  seq_mode_e mode_d;

  // Bus decode
  logic wr_en;
  logic rd_en;
  logic live_hit;
  logic [3:0] live_idx;
  logic live_wr_refused;
  logic addr_ok;
  // Decoded command pulses last exactly one access cycle
  logic cmd_load;
  logic cmd_store;
  logic [2:0] sw_pulse;
  trig_s trig;

  // Advance decision
  logic adv_go;
  logic [4:0] adv_idx;
  param_set_s cur_set;

  // Is a trigger source firing; async sources only through software pulses
  function automatic logic src_hit(input logic [3:0] src, input trig_s t, input logic sync);
    logic r;
    r = 1'b0;
    // Frame start is not handled here; path 1 treats it on its own
    // The sync argument separates sources sampled at frame start from software ones
    unique case (src)
      `SRC_LINE1: r = sync & t.lines[0];
      `SRC_LINE3: r = sync & t.lines[1];
      `SRC_LINE4: r = sync & t.lines[2];
      `SRC_CNT2: r = sync & t.counter2_end;
      `SRC_SW1: r = ~sync & t.sw[0];
      `SRC_SW2: r = ~sync & t.sw[1];
      `SRC_SW3: r = ~sync & t.sw[2];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : src_hit

  // Word index of a live address, valid only when in range
  function automatic logic [3:0] live_word(input logic [11:0] a);
    logic [11:0] off;
    // Wraps below the window; live_hit checks the range on its own
    off = a - `OFS_LIVE_BASE;
    return off[5:2];
  endfunction : live_word

  // Default saved configuration
  function automatic set_words_t default_words();
    // Used at reset for the live words, the active set and every stored set
    return {`DEF_W9, `DEF_W8, `DEF_W7, `DEF_W6, `DEF_W5,
            `DEF_W4, `DEF_W3, `DEF_W2, `DEF_W1, `DEF_W0};
  endfunction : default_words

  // APB access phase; zero wait states
  // The slave never stretches a transfer, so pready is a constant
  assign pready_o = 1'b1;
  assign wr_en = psel_i & penable_i & pwrite_i;
  // Read data is fetched in the setup phase and stands through the access phase
  assign rd_en = psel_i & ~penable_i & ~pwrite_i;
  assign live_idx = live_word(paddr_i);
  assign live_hit = (paddr_i >= `OFS_LIVE_BASE) && (paddr_i[1:0] == 2'b00) &&
                    (live_idx < 4'(`LIVE_WORDS)) && (paddr_i < 12'h080);
  assign addr_ok = live_hit || paddr_i == `OFS_CTRL || paddr_i == `OFS_CMD ||
                   paddr_i == `OFS_STATUS || paddr_i == `OFS_AUX;
  // Live writes are refused while sets are being applied
  assign live_wr_refused = live_hit && pwrite_i && (mode_q == SEQ_ARMED || mode_q == SEQ_RUN);
  assign pslverr_o = psel_i & penable_i & (~addr_ok | live_wr_refused);

  // Command pulses decoded from the write-only command word
  // Several command bits may be set in one write; each of them then acts
  assign cmd_load = wr_en && paddr_i == `OFS_CMD && pwdata_i[`CMD_LOAD_BIT];
  assign cmd_store = wr_en && paddr_i == `OFS_CMD && pwdata_i[`CMD_STORE_BIT];
  assign sw_pulse = (wr_en && paddr_i == `OFS_CMD) ? pwdata_i[`CMD_SW_LSB +: 3] : 3'h0;

  // Gather the trigger inputs into one bundle for the source decoder
  assign trig.frame_start = frame_start_i;
  assign trig.counter2_end = counter2_end_i;
  assign trig.lines = trig_lines_i;
  assign trig.sw = sw_pulse;

  // Flags combine into the effective mode; auto adjustment shuts it all off
  always_comb begin
    // Keeps the present mode on any path that does not name one
    mode_d = mode_q;
    if (auto_flag_q || (!cfg_flag_q && !run_flag_q)) begin
      mode_d = SEQ_OFF; // Both off: disabled
    end else if (run_flag_q) begin
      // Running takes precedence; wait for the first frame start
      mode_d = (mode_q == SEQ_RUN) ? SEQ_RUN : SEQ_ARMED;
      if (mode_q == SEQ_ARMED && frame_start_i) begin
        mode_d = SEQ_RUN;
      end
    end else begin
      mode_d = SEQ_CFG; // Config flag on, run off
    end
  end

  // Mode register
  // One register, so every consumer sees the same mode within a cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= SEQ_OFF;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Advance: first frame loads set 0, later frames follow the paths
  assign cur_set = set_mem_q[cur_q];
  always_comb begin
    adv_go = 1'b0;
    adv_idx = cur_q;
    unique case (mode_q)
      SEQ_ARMED: begin
        // Armed: only the first frame start matters, and it always picks set zero
        if (frame_start_i) begin
          adv_go = 1'b1;
          adv_idx = `FIRST_SET_INDEX;
        end
      end
      SEQ_RUN: begin
        if (frame_start_i) begin
          // Sync sources are sampled at the frame start; path 0 wins
          if (src_hit(cur_set.path0_src, trig, 1'b1)) begin
            adv_go = 1'b1;
            adv_idx = cur_set.path0_next;
          end else if (src_hit(cur_set.path1_src, trig, 1'b1) ||
                       cur_set.path1_src == `SRC_FRAME) begin
            // Path 1 also accepts the frame start itself as its source
            adv_go = 1'b1;
            adv_idx = cur_set.path1_next;
          end
        end else if (src_hit(cur_set.path0_src, trig, 1'b0)) begin
          adv_go = 1'b1; // Software signals load at once, unaligned to frames
          adv_idx = cur_set.path0_next;
        end else if (src_hit(cur_set.path1_src, trig, 1'b0)) begin
          // Path 1 software signal, only when path 0 did not fire
          adv_go = 1'b1;
          adv_idx = cur_set.path1_next;
        end
      end
      default: begin
        // Off and configuration mode never apply a set to acquisitions
        adv_go = 1'b0;
      end
    endcase
  end

  // Control register and selector
  // All fields are written together from one word
  // Flags stay as written even while auto adjustment holds sequencing off
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Reset leaves sequencing off with set zero selected
      cfg_flag_q <= 1'b0;
      run_flag_q <= 1'b0;
      auto_flag_q <= 1'b0;
      sel_q <= 5'h00;
    end else if (wr_en && paddr_i == `OFS_CTRL) begin
      cfg_flag_q <= pwdata_i[`CTRL_CFG_BIT];
      run_flag_q <= pwdata_i[`CTRL_RUN_BIT];
      auto_flag_q <= pwdata_i[`CTRL_AUTO_BIT];
      sel_q <= pwdata_i[`CTRL_SEL_LSB +: 5]; // Index 0..31
    end
  end

  // Non-sequenced live setting; no set load ever writes it
  // Writable in every mode, since it belongs to no stored set
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aux_q <= `DEF_AUX;
    end else if (wr_en && paddr_i == `OFS_AUX) begin
      aux_q <= pwdata_i;
    end
  end

  // Live words: host edits, or a load strobe copies the selected set in one cycle
  // A load outranks a host edit of the same cycle; one transfer cannot carry both
  // Loads are ignored while armed or running, so live keeps the pre-sequencing values
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Reset returns the live words to the default saved configuration
      live_q <= default_words();
    end else if (cmd_load && mode_q != SEQ_ARMED && mode_q != SEQ_RUN) begin
      live_q <= set_words_t'(set_mem_q[sel_q]); // Whole set at once
    end else if (wr_en && live_hit && !live_wr_refused) begin
      live_q[live_idx] <= pwdata_i; // Software edits the live copy
    end
  end

  // Set store: defaults at reset, written back only in configuration mode
  // Reset fills all entries at once: a wide fan-out, traded for plain volatile storage
  // A store outside configuration mode is dropped without an error response
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < `SET_COUNT; i++) begin
        set_mem_q[i] <= param_set_s'(default_words());
      end
    end else if (cmd_store && mode_q == SEQ_CFG) begin
      set_mem_q[sel_q] <= param_set_s'(live_q); // Editing only here
    end
  end

  // Active set: follows live outside sequencing, else the current set
  // The load pulse lines up with the first cycle of the new active set
  // Outside sequencing the active set trails the live words by one cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Defaults reach the acquisition side and set zero counts as current
      active_q <= param_set_s'(default_words());
      cur_q <= 5'h00;
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= adv_go;
      if (adv_go) begin
        active_q <= set_mem_q[adv_idx]; // Every sequenced field replaced
        cur_q <= adv_idx; // Stays current until the next advance
      end else if (mode_q != SEQ_ARMED && mode_q != SEQ_RUN) begin
        active_q <= param_set_s'(live_q);
      end
    end
  end

  // Read data; live reads show the pre-sequencing values
  // Taking the data in the setup phase spares the access phase a wait state
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (rd_en) begin
      // Command word and unmapped addresses read as zero
      prdata_o <= 32'h00000000;
      if (live_hit) begin
        prdata_o <= live_q[live_idx];
      end else if (paddr_i == `OFS_CTRL) begin
        prdata_o <= {19'h00000, sel_q, 5'h00, auto_flag_q, run_flag_q, cfg_flag_q};
      end else if (paddr_i == `OFS_STATUS) begin
        prdata_o <= {21'h000000, mode_q == SEQ_ARMED, mode_q == SEQ_CFG,
                     mode_q == SEQ_RUN, 3'h0, cur_q};
      end else if (paddr_i == `OFS_AUX) begin
        prdata_o <= aux_q;
      end
    end
  end

  // Outputs to the acquisition side
  // All but seq_running_o come straight from a register; seq_running_o is decoded from mode_q
  assign active_cfg_o = active_q;
  assign aux_setting_o = aux_q;
  assign current_set_o = cur_q;
  assign set_loaded_o = loaded_q;
  assign seq_running_o = (mode_q == SEQ_RUN);

endmodule : parameter_set_sequencer

// file: hdl/set_seq_regs.svh
// Register offsets, field positions, reset values and the function list of the set sequencer
// Function
// - Auto adjustment enabled disables set sequencing
// - Thirty-two stored sets, index 0 to 31
// - After reset all sets hold defaults
// - Config mode: flag on, run off; no apply
// - Run flag applies sets, refuses set editing
// - Both flags off means sequencing disabled
// - Run: live writes refused, reads give old
// - Sets volatile; reset restores defaults
// - No saving sets into nonvolatile storage
// - Camera follows live configuration writes
// - Loads never touch non-sequenced live parameters
// - Set load replaces all sequenced parameters at once
// - Latest loaded set is current until advance
// - Sets applied one after another per capture
// - Set holds all listed camera control values
// - Set holds advance control incl. path choice
// - First set is 0, loaded at first frame
// - Two paths, each next index and trigger
`ifndef SET_SEQ_REGS_SVH
`define SET_SEQ_REGS_SVH

// Byte offsets on the APB
`define OFS_CTRL 12'h000
`define OFS_CMD 12'h004
`define OFS_STATUS 12'h008
`define OFS_AUX 12'h00C
`define OFS_LIVE_BASE 12'h040
`define LIVE_WORDS 10
`define SET_COUNT 32
`define FIRST_SET_INDEX 5'h00

// Control register fields
`define CTRL_CFG_BIT 0
`define CTRL_RUN_BIT 1
`define CTRL_AUTO_BIT 2
`define CTRL_SEL_LSB 8
// Command register fields (write-only pulses)
`define CMD_LOAD_BIT 0
`define CMD_STORE_BIT 1
`define CMD_SW_LSB 2
// Status register fields
`define STAT_RUN_BIT 8
`define STAT_CFG_BIT 9
`define STAT_ARMED_BIT 10

// Trigger source codes of an advance path
`define SRC_NONE 4'h0
`define SRC_LINE1 4'h1
`define SRC_LINE3 4'h2
`define SRC_LINE4 4'h3
`define SRC_FRAME 4'h4
`define SRC_CNT2 4'h5
`define SRC_SW1 4'h6
`define SRC_SW2 4'h7
`define SRC_SW3 4'h8

// Default saved configuration, word 0 upward
`define DEF_W0 32'h01002710
`define DEF_W1 32'h00640000
`define DEF_W2 32'h00000000
`define DEF_W3 32'h00000000
`define DEF_W4 32'h00000000
`define DEF_W5 32'h028001E0
`define DEF_W6 32'h01000000
`define DEF_W7 32'h00000000
`define DEF_W8 32'h00000024
`define DEF_W9 32'h00000000
`define DEF_AUX 32'h00000000

`endif

// file: hdl/set_seq_pkg.sv
// Types shared by the parameter set sequencer
package set_seq_pkg;

  // One stored set: camera control words 0..8, advance control in word 9
  typedef struct packed {
    logic [13:0] spare;
    logic [3:0] path1_src;
    logic [4:0] path1_next;
    logic [3:0] path0_src;
    logic [4:0] path0_next;
    logic [18:0] flag_spare;
    logic rate_enable;
    logic metadata_mode_on;
    logic lookup_table_on;
    logic reverse_y;
    logic reverse_x;
    logic center_y;
    logic center_x;
    logic [2:0] row_merge_factor;
    logic [2:0] column_merge_factor;
    logic [3:0] counter2_reset_src;
    logic [3:0] pattern_choice;
    logic [7:0] chunk_enable;
    logic [15:0] color_transform;
    logic [7:0] color_saturation;
    logic [7:0] color_hue;
    logic [15:0] white_balance_factor;
    logic [15:0] roi_height;
    logic [15:0] roi_width;
    logic [15:0] roi_offset_y;
    logic [15:0] roi_offset_x;
    logic [3:0] counter2_event_src;
    logic [3:0] bit_shift_amount;
    logic [11:0] dark_offset;
    logic [11:0] gain;
    logic [15:0] counter2_duration;
    logic [15:0] timer1_duration;
    logic [15:0] timer1_delay;
    logic [15:0] capture_rate_value;
    logic [23:0] shutter_interval;
    logic [7:0] pixel_layout_select;
  } param_set_s;

  typedef logic [9:0][31:0] set_words_t;

  // Sequencer modes, Gray along off -> config -> armed -> running
  typedef enum logic [1:0] {
    SEQ_OFF = 2'b00,
    SEQ_CFG = 2'b01,
    SEQ_ARMED = 2'b11,
    SEQ_RUN = 2'b10
  } seq_mode_e;

  // Trigger levels and events seen by the advance logic
  typedef struct packed {
    logic frame_start;
    logic counter2_end;
    logic [2:0] lines;
    logic [2:0] sw;
  } trig_s;

endpackage : set_seq_pkg

// file: tb/pss_assertions.sv
// Port-level checks of the parameter set sequencer
`timescale 1ns/10ps
module pss_assertions
  import set_seq_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic pslverr_o,
  input wire logic frame_start_i,
  input wire param_set_s active_cfg_o,
  input wire logic [31:0] aux_setting_o,
  input wire logic [4:0] current_set_o,
  input wire logic set_loaded_o,
  input wire logic seq_running_o
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Access phase of a write into the live word window
  logic live_wr;
  assign live_wr = psel_i && penable_i && pwrite_i && paddr_i >= 12'h040 && paddr_i <= 12'h064;
  a_first_frame: assert property ($rose(seq_running_o) |-> $past(frame_start_i))
    else $error("run began without a frame start");
  a_first_index: assert property ($rose(seq_running_o) |-> current_set_o == 5'h00)
    else $error("first set is not set zero");
  a_load_pulse: assert property ($rose(seq_running_o) |-> set_loaded_o)
    else $error("no load pulse after first set");
  a_active_loaded: assert property (seq_running_o && !$stable(active_cfg_o)
    |-> set_loaded_o)
    else $error("active changed in run without load pulse");
  a_run_cause: assert property (seq_running_o && $past(seq_running_o)
    && !$stable(active_cfg_o) |-> $past(frame_start_i)
    || $past(psel_i && penable_i && pwrite_i && paddr_i == 12'h004))
    else $error("active changed in run without a trigger");
  a_live_refused: assert property (live_wr && seq_running_o |-> pslverr_o)
    else $error("live write accepted while running");
  a_err_access: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error outside access phase");
  a_aux_kept: assert property (!$stable(aux_setting_o)
    |-> $past(psel_i && penable_i && pwrite_i && paddr_i == 12'h00C))
    else $error("aux setting changed without a write");
  // Main scenarios reached
  c_run: cover property ($rose(seq_running_o));
  c_last: cover property (set_loaded_o && current_set_o == 5'h1F);
  c_refuse: cover property (live_wr && pslverr_o);
endmodule : pss_assertions

bind parameter_set_sequencer pss_assertions u_chk (.core_clk_i, .rst_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pslverr_o, .frame_start_i, .active_cfg_o, .aux_setting_o,
  .current_set_o, .set_loaded_o, .seq_running_o);

// file: tb/acq_partner.sv
// Acquisition side model: issues frame start triggers after a chosen delay
`timescale 1ns/10ps
module acq_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fire_i,
  input wire logic [3:0] gap_i,
  output logic frame_start_o,
  output logic busy_o
);
  logic [3:0] cnt_q;  // Cycles left before the trigger
  // A zero gap answers promptly, a longer one models a slow sensor
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      busy_o <= 1'b0;
      frame_start_o <= 1'b0;
    end else begin
      frame_start_o <= busy_o && cnt_q == 4'h0;
      if (fire_i) begin
        busy_o <= 1'b1;
        cnt_q <= gap_i;
      end else if (busy_o) begin
        busy_o <= cnt_q != 4'h0;
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : acq_partner

// file: tb/parameter_set_sequencer_tb_top.sv
// Self-checking bench for the parameter set sequencer
`timescale 1ns/10ps
`include "set_seq_regs.svh"
module parameter_set_sequencer_tb_top
  import set_seq_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic fire = 1'b0;
  logic [3:0] gap = 4'h0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [2:0] trig_lines_i = 3'h0;
  logic counter2_end_i = 1'b0;
  logic [31:0] prdata_o, aux_setting_o, rd, aux_m;
  logic pready_o, pslverr_o, set_loaded_o, seq_running_o, frame_start_i, err;
  param_set_s active_cfg_o;
  logic [4:0] current_set_o;
  logic [319:0] live_m, defv;  // Model of live words and defaults
  logic [319:0] sets_m [32];  // Model of the stored sets
  logic [31:0] seed = 32'h0000B8DB;
  int mismatches = 0;
  int total_checks = 0;
  always #10 core_clk_i = ~core_clk_i;
  parameter_set_sequencer DUT (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .frame_start_i, .counter2_end_i,
    .trig_lines_i, .active_cfg_o, .aux_setting_o, .current_set_o, .set_loaded_o,
    .seq_running_o);
  acq_partner PART (.clk_i(core_clk_i), .rst_i, .fire_i(fire), .gap_i(gap),
    .frame_start_o(frame_start_i), .busy_o());
  task automatic give_verdict();
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [319:0] s, input logic [319:0] x);
    total_checks++;
    if (s !== x) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", n, x, s);
    end
  endtask : chk
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // One APB transfer; the answer is waited for under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (pready_o !== 1'b1) begin
      mismatches++;
      give_verdict();
    end
    @(posedge core_clk_i);
  endtask : apb
  task automatic act_chk(input logic [319:0] x);
    #1;
    chk("active", active_cfg_o, x);
    @(posedge core_clk_i);
  endtask : act_chk
  // Ask the partner for a frame start, then check what it loaded
  task automatic frame(input logic [319:0] x, input logic [4:0] c, input logic ld);
    int n;
    logic [31:0] v;
    n = 0;
    v = rnd();
    gap <= {2'b00, v[1:0]};
    fire <= 1'b1;
    @(posedge core_clk_i);
    fire <= 1'b0;
    while (frame_start_i !== 1'b1 && n < 30) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n >= 30) begin
      mismatches++;
      give_verdict();
    end
    // The load pulse stands only in the cycle right after the loading edge
    #1;
    chk("frame active", active_cfg_o, x);
    chk("current", current_set_o, c);
    chk("loaded", set_loaded_o, ld);
    @(posedge core_clk_i);
  endtask : frame
  // Reset also returns the model to the defaults, as the sets are volatile
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    live_m = defv;
    for (int k = 0; k < 32; k++) sets_m[k] = defv;
    @(posedge core_clk_i);
  endtask : do_reset
  initial begin
    logic [31:0] v;
    logic [4:0] ids [3];
    logic [31:0] pw [3];
    ids = '{5'h00, 5'h1F, 5'h05};
    pw = '{32'h00013E00, 32'h00010025, 32'h000000BF};
    defv = {`DEF_W9, `DEF_W8, `DEF_W7, `DEF_W6, `DEF_W5, `DEF_W4, `DEF_W3, `DEF_W2, `DEF_W1,
      `DEF_W0};
    do_reset();
    chk("reset active", active_cfg_o, defv);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("status", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    aux_m = rnd();
    apb(1'b1, `OFS_AUX, aux_m);
    // Fill sets 0, 31 and 5 in configuration mode
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `OFS_CTRL, {19'h0, ids[i], 8'h01});
      for (int w = 0; w < 10; w++) begin
        v = (w == 9) ? pw[i] : rnd();
        apb(1'b1, 12'(`OFS_LIVE_BASE + 4 * w), v);
        live_m[32*w +: 32] = v;
      end
      act_chk(live_m);
      apb(1'b1, `OFS_CMD, 32'h2);
      sets_m[ids[i]] = live_m;
    end
    apb(1'b1, `OFS_CTRL, 32'h1);
    apb(1'b1, `OFS_CMD, 32'h1); // Load set 0 before touching it
    live_m = sets_m[0];
    for (int w = 0; w < 10; w++) begin
      apb(1'b0, 12'(`OFS_LIVE_BASE + 4 * w), 32'h0);
      chk("live word", rd, live_m[32*w +: 32]);
    end
    act_chk(live_m);
    // Sequencing: set 0 first, then both advance paths
    apb(1'b1, `OFS_CTRL, 32'h2);
    frame(sets_m[0], 5'h00, 1'b1);
    apb(1'b1, `OFS_LIVE_BASE, 32'hFFFFFFFF);
    chk("live refused", err, 1'b1);
    apb(1'b0, `OFS_LIVE_BASE, 32'h0);
    chk("live read", rd, live_m[31:0]);
    frame(sets_m[31], 5'h1F, 1'b1);
    trig_lines_i <= 3'h1;
    frame(sets_m[5], 5'h05, 1'b1);
    trig_lines_i <= 3'h0;
    frame(sets_m[5], 5'h05, 1'b0);
    counter2_end_i <= 1'b1;
    frame(sets_m[31], 5'h1F, 1'b1);
    counter2_end_i <= 1'b0;
    chk("aux", aux_setting_o, aux_m);
    apb(1'b1, `OFS_CTRL, 32'h6);
    #1;
    chk("auto stops", seq_running_o, 1'b0);
    @(posedge core_clk_i);
    frame(live_m, 5'h1F, 1'b0);
    apb(1'b1, `OFS_CTRL, 32'h0);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("status flags", rd[10:8], 3'h0);
    apb(1'b1, `OFS_CTRL, 32'h2);
    frame(sets_m[0], 5'h00, 1'b1);
    do_reset();
    chk("active after reset", active_cfg_o, defv);
    apb(1'b1, `OFS_CTRL, 32'h00001F00); // Sequencing off before set access
    apb(1'b1, `OFS_CMD, 32'h1);
    apb(1'b0, 12'h064, 32'h0);
    chk("set 31 default", rd, `DEF_W9);
    give_verdict();
  end
endmodule : parameter_set_sequencer_tb_top
